// ---- core/erc_top.sv ----
// Check and state-setup engine for re-entry into a protected enclave.
// Assumes operands are sampled on start and stay stable one cycle; all inputs are on the core clock.
// Summary of operation
// - Fault protection if structure pointer is not 4KByte aligned.
// - Page fault if structure pointer is outside protected page memory.
// - In wide mode, non-canonical exit point gives protection fault.
// - Another enclave operation on the same structure gives protection fault.
// - Page fault if map entry invalid, blocked, pending or modified.
// - Page fault on address mismatch or wrong page type.
// - Protection fault if save area offset not 4KByte aligned.
// - Protection fault if FS or GS base offset not 4KByte aligned.
// - Protection fault if reserved flag bits are set.
// - Protection fault if enclave not initialized.
// - Outside wide mode, nonzero bases or stack B bit zero fault.
// - Outside wide mode, unusable or expand-down data segment faults.
// - Fault when operating mode differs from enclave's recorded mode.
// - With extended state available but no OS extended saving, feature mask must equal exactly 3.
// - With OS extended saving, feature mask must be subset of control reg.
// - Save area bytes 520-527 zero; vector at 512 subset of mask.
// - Outside wide mode, FS or GS segment outside data segment faults.
// - On success record exit point in the structure.
// - With OS extended saving, save control reg and load feature mask.
// - Opt-out entry saves and clears trap flag; pops cannot set it.
// - Suppress outside-range code breakpoints; opt-out also in-range ones.
// - Opt-out suppresses monitoring except fixed counters; sets status bits 60, 63 if any monitor is active.
// - Zero save frame count faults; success decrements it.
`timescale 1ns/1ns
`default_nettype none
module erc_top
    import erc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [63:0] structPointerOperand,
    input wire logic [63:0] exitPointOperand,
    input wire logic wideModeFlag,
    input wire logic inProtectedMemory,
    input wire logic structBusy,
    input wire erc_map_entry_type mapEntry,
    input wire erc_thread_struct_type threadStruct,
    input wire logic enclaveInitialized,
    input wire logic enclaveWideMode,
    input wire logic [63:0] enclaveBase,
    input wire erc_segment_type segState,
    input wire logic extStateAvailable,
    input wire logic osExtStateEnable,
    input wire logic [63:0] extendedFeatureMask,
    input wire logic [63:0] extendedControlIn,
    input wire logic [127:0] saveAreaHeader,
    input wire logic trapFlagIn,
    input wire logic flagPopTrap,
    input wire logic anyMonitorActive,
    output logic done,
    output erc_fault_type fault,
    output logic [63:0] asyncExitPoint,
    output logic [31:0] saveFrameCount,
    output logic [63:0] extendedControlReg,
    output logic [63:0] savedExtendedControl,
    output logic savedTrapFlag,
    output logic trapFlag,
    output logic optOutActive,
    output logic suppressOutsideCodeBp,
    output logic suppressInsideBp,
    output logic suppressMonitoring,
    output logic [63:0] perfGlobalStatus
);
    // ==========================================================
    // Page and pointer checks
    logic alignFault;
    logic pageFault;
    logic fsOutside;
    logic gsOutside;

    erc_page_check pageCheck (
        .structPointer(structPointerOperand),
        .inProtectedMemory(inProtectedMemory),
        .mapEntry(mapEntry),
        .alignFault(alignFault),
        .pageFault(pageFault)
    );

    erc_seg_contain fsCheck (
        .baseOffset(threadStruct.fsBaseOffset[31:0]),
        .enclaveBase(enclaveBase[31:0]),
        .segLimit(threadStruct.fsLimit),
        .dsLimit(segState.dsLimit),
        .outside(fsOutside)
    );

    erc_seg_contain gsCheck (
        .baseOffset(threadStruct.gsBaseOffset[31:0]),
        .enclaveBase(enclaveBase[31:0]),
        .segLimit(threadStruct.gsLimit),
        .dsLimit(segState.dsLimit),
        .outside(gsOutside)
    );

    // ==========================================================
    // Protection checks
    logic protFault;
    logic exitCanonical;
    logic [63:0] hdrUpper;
    logic [63:0] hdrVector;

    always_comb begin
        exitCanonical = &exitPointOperand[63:47] || ~|exitPointOperand[63:47];
        hdrVector = saveAreaHeader[63:0];
        // Every header byte after the bit vector must be clear
        hdrUpper = saveAreaHeader[127:64];
        protFault = alignFault;
        if (wideModeFlag && !exitCanonical) begin
            protFault = 1'b1;
        end
        if (structBusy) begin
            protFault = 1'b1;
        end
        if (|threadStruct.saveAreaOffset[ERC_PAGE_BITS-1:0]) begin
            protFault = 1'b1;
        end
        if (|threadStruct.fsBaseOffset[ERC_PAGE_BITS-1:0] || |threadStruct.gsBaseOffset[ERC_PAGE_BITS-1:0]) begin
            protFault = 1'b1;
        end
        if (|(threadStruct.flags & ERC_FLAGS_RSVD_MASK)) begin
            protFault = 1'b1;
        end
        if (!enclaveInitialized) begin
            protFault = 1'b1;
        end
        if (!wideModeFlag) begin
            if (!segState.csBaseZero || !segState.dsBaseZero
                || (segState.esUsable && !segState.esBaseZero)
                || (segState.ssUsable && (!segState.ssBaseZero || !segState.ssBigBit))) begin
                protFault = 1'b1;
            end
            if (!segState.dsUsable || (segState.dsSFlag && !segState.dsBit11 && segState.dsBit10)) begin
                protFault = 1'b1;
            end
            if (fsOutside || gsOutside) begin
                protFault = 1'b1;
            end
        end
        if (wideModeFlag != enclaveWideMode) begin
            protFault = 1'b1;
        end
        if (extStateAvailable && !osExtStateEnable && extendedFeatureMask != ERC_EXTENDED_FEATURE_MASK_LEGACY) begin
            protFault = 1'b1;
        end
        if (osExtStateEnable && (extendedFeatureMask & extendedControlIn) != extendedFeatureMask) begin
            protFault = 1'b1;
        end
        if (hdrUpper != ERC_XSTATE_HDR_ZERO || (hdrVector & ~extendedFeatureMask) != ERC_RESET_WORD) begin
            protFault = 1'b1;
        end
        if (threadStruct.saveFrameCount == ERC_RESET_COUNT) begin
            protFault = 1'b1;
        end
    end

    // ==========================================================
    // Result and state update
    logic next_done;
    erc_fault_type next_fault;
    logic [63:0] next_asyncExitPoint;
    logic [31:0] next_saveFrameCount;
    logic [63:0] next_extendedControlReg;
    logic [63:0] next_savedExtendedControl;
    logic next_savedTrapFlag;
    logic next_trapFlag;
    logic next_optOutActive;
    logic next_suppressOutsideCodeBp;
    logic next_suppressInsideBp;
    logic next_suppressMonitoring;
    logic [63:0] next_perfGlobalStatus;
    logic optOut;

    always_comb begin
        optOut = !threadStruct.flags[0];
        next_done = 1'b0;
        next_fault = fault;
        next_asyncExitPoint = asyncExitPoint;
        next_saveFrameCount = saveFrameCount;
        next_extendedControlReg = extendedControlReg;
        next_savedExtendedControl = savedExtendedControl;
        next_savedTrapFlag = savedTrapFlag;
        next_trapFlag = trapFlagIn;
        next_optOutActive = optOutActive;
        next_suppressOutsideCodeBp = suppressOutsideCodeBp;
        next_suppressInsideBp = suppressInsideBp;
        next_suppressMonitoring = suppressMonitoring;
        next_perfGlobalStatus = perfGlobalStatus;
        if (optOutActive && flagPopTrap) begin
            next_trapFlag = 1'b0;
        end
        if (start) begin
            next_done = 1'b1;
            if (pageFault) begin
                next_fault = ERC_FAULT_PF;
            end else if (protFault) begin
                next_fault = ERC_FAULT_GP;
            end else begin
                next_fault = ERC_FAULT_NONE;
                next_asyncExitPoint = exitPointOperand;
                next_saveFrameCount = threadStruct.saveFrameCount - 32'h0000_0001;
                if (osExtStateEnable) begin
                    next_savedExtendedControl = extendedControlIn;
                    next_extendedControlReg = extendedFeatureMask;
                end
                next_optOutActive = optOut;
                next_suppressOutsideCodeBp = 1'b1;
                next_suppressInsideBp = optOut;
                next_suppressMonitoring = optOut;
                if (optOut) begin
                    next_savedTrapFlag = trapFlagIn;
                    next_trapFlag = 1'b0;
                    if (anyMonitorActive) begin
                        next_perfGlobalStatus[ERC_PERF_OPTOUT_BIT] = 1'b1;
                        next_perfGlobalStatus[ERC_PERF_SUPPR_BIT] = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            done <= 1'b0;
            fault <= ERC_FAULT_NONE;
            asyncExitPoint <= ERC_RESET_WORD;
            saveFrameCount <= ERC_RESET_COUNT;
            extendedControlReg <= ERC_RESET_WORD;
            savedExtendedControl <= ERC_RESET_WORD;
            savedTrapFlag <= 1'b0;
            trapFlag <= 1'b0;
            optOutActive <= 1'b0;
            suppressOutsideCodeBp <= 1'b0;
            suppressInsideBp <= 1'b0;
            suppressMonitoring <= 1'b0;
            perfGlobalStatus <= ERC_RESET_WORD;
        end else begin
            done <= next_done;
            fault <= next_fault;
            asyncExitPoint <= next_asyncExitPoint;
            saveFrameCount <= next_saveFrameCount;
            extendedControlReg <= next_extendedControlReg;
            savedExtendedControl <= next_savedExtendedControl;
            savedTrapFlag <= next_savedTrapFlag;
            trapFlag <= next_trapFlag;
            optOutActive <= next_optOutActive;
            suppressOutsideCodeBp <= next_suppressOutsideCodeBp;
            suppressInsideBp <= next_suppressInsideBp;
            suppressMonitoring <= next_suppressMonitoring;
            perfGlobalStatus <= next_perfGlobalStatus;
        end
    end

    // ==========================================================
    // Assertions
    a_misalign_faults: assert property (@(posedge clock) disable iff (rst)
        start && |structPointerOperand[11:0] |=> done && fault != ERC_FAULT_NONE)
        else $error("misaligned pointer not faulted");

    a_outside_pf: assert property (@(posedge clock) disable iff (rst)
        start && !inProtectedMemory |=> fault == ERC_FAULT_PF)
        else $error("pointer outside protected memory not page faulted");

    a_exit_canonical: assert property (@(posedge clock) disable iff (rst)
        start && wideModeFlag && !(&exitPointOperand[63:47] || ~|exitPointOperand[63:47]) |=> fault != ERC_FAULT_NONE)
        else $error("non-canonical exit point not faulted");

    a_header_zero: assert property (@(posedge clock) disable iff (rst)
        start && |saveAreaHeader[127:64] |=> fault != ERC_FAULT_NONE)
        else $error("nonzero save area header not faulted");

    a_busy_faults: assert property (@(posedge clock) disable iff (rst)
        start && structBusy && !pageFault |=> fault == ERC_FAULT_GP)
        else $error("busy structure not faulted");

    a_mode_mismatch: assert property (@(posedge clock) disable iff (rst)
        start && wideModeFlag != enclaveWideMode |=> fault != ERC_FAULT_NONE)
        else $error("mode mismatch not faulted");

    a_count_decrement: assert property (@(posedge clock) disable iff (rst)
        start ##1 fault == ERC_FAULT_NONE |-> saveFrameCount == $past(threadStruct.saveFrameCount) - 32'h1)
        else $error("frame count not decremented");

    a_fault_no_change: assert property (@(posedge clock) disable iff (rst)
        start ##1 fault != ERC_FAULT_NONE |-> $stable(asyncExitPoint) && $stable(extendedControlReg))
        else $error("state changed on fault");

    a_exit_recorded: assert property (@(posedge clock) disable iff (rst)
        start ##1 fault == ERC_FAULT_NONE |-> asyncExitPoint == $past(exitPointOperand))
        else $error("exit point not recorded");

    a_optout_trap: assert property (@(posedge clock) disable iff (rst)
        optOutActive && flagPopTrap |=> !trapFlag)
        else $error("trap flag set inside opt-out enclave");

    a_perf_bits: assert property (@(posedge clock) disable iff (rst)
        start ##1 fault == ERC_FAULT_NONE && suppressMonitoring && $past(anyMonitorActive)
        |-> perfGlobalStatus[60] && perfGlobalStatus[63])
        else $error("global status bits not set");
endmodule
`default_nettype wire

// ---- core/erc_pkg.sv ----
// Package for the enclave re-entry check block.
// Assumes all operands are presented as registered inputs on the core clock.
package erc_pkg;

    // ==========================================================
    // Widths and constants
    localparam int ERC_ADDR_W = 64;
    localparam int ERC_PAGE_BITS = 12;
    localparam logic [63:0] ERC_FLAGS_RSVD_MASK = 64'hFFFF_FFFF_FFFF_FFFE;
    localparam logic [63:0] ERC_EXTENDED_FEATURE_MASK_LEGACY = 64'h0000_0000_0000_0003;
    localparam logic [3:0] ERC_PT_THREAD = 4'h1;
    localparam logic [63:0] ERC_XSTATE_HDR_ZERO = 64'h0000_0000_0000_0000;
    localparam int ERC_PERF_OPTOUT_BIT = 60;
    localparam int ERC_PERF_SUPPR_BIT = 63;
    localparam logic [63:0] ERC_RESET_WORD = 64'h0000_0000_0000_0000;
    localparam logic [31:0] ERC_RESET_COUNT = 32'h0000_0000;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {ERC_FAULT_NONE, ERC_FAULT_GP, ERC_FAULT_PF} erc_fault_type;

    typedef struct packed {
        logic valid;
        logic blocked;
        logic pending;
        logic modified;
        logic [3:0] pageType;
        logic [63:0] enclaveAddress;
    } erc_map_entry_type;

    typedef struct packed {
        logic [63:0] saveAreaOffset;
        logic [63:0] fsBaseOffset;
        logic [63:0] gsBaseOffset;
        logic [63:0] flags;
        logic [31:0] saveFrameCount;
        logic [31:0] fsLimit;
        logic [31:0] gsLimit;
    } erc_thread_struct_type;

    typedef struct packed {
        logic csBaseZero;
        logic dsBaseZero;
        logic esUsable;
        logic esBaseZero;
        logic ssUsable;
        logic ssBaseZero;
        logic ssBigBit;
        logic dsUsable;
        logic dsSFlag;
        logic dsBit11;
        logic dsBit10;
        logic [31:0] dsLimit;
    } erc_segment_type;

endpackage

// ---- core/erc_page_check.sv ----
// Page-map and pointer checks on the thread control structure.
// Assumes map entry and pointer are stable while the request is presented.
`timescale 1ns/1ns
`default_nettype none
module erc_page_check
    import erc_pkg::*;
(
    input wire logic [63:0] structPointer,
    input wire logic inProtectedMemory,
    input wire erc_map_entry_type mapEntry,
    output logic alignFault,
    output logic pageFault
);
    always_comb begin
        alignFault = |structPointer[ERC_PAGE_BITS-1:0];
        pageFault = !inProtectedMemory;
        if (!mapEntry.valid || mapEntry.blocked || mapEntry.pending || mapEntry.modified) begin
            pageFault = 1'b1;
        end
        if (mapEntry.enclaveAddress != structPointer || mapEntry.pageType != ERC_PT_THREAD) begin
            pageFault = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- core/erc_seg_contain.sv ----
// Checks that a segment built from base offset and limit lies within the data segment.
// Assumes 32-bit arithmetic outside 64-bit mode.
`timescale 1ns/1ns
`default_nettype none
module erc_seg_contain
    import erc_pkg::*;
(
    input wire logic [31:0] baseOffset,
    input wire logic [31:0] enclaveBase,
    input wire logic [31:0] segLimit,
    input wire logic [31:0] dsLimit,
    output logic outside
);
    logic [31:0] segBase;
    logic [31:0] segTop;
    always_comb begin
        segBase = baseOffset + enclaveBase;
        segTop = segBase + segLimit;
        // Wrap-around needs a data segment with no holes
        if (segTop < segBase) begin
            outside = dsLimit != 32'hFFFF_FFFF;
        end else begin
            outside = segTop > dsLimit;
        end
    end
endmodule
`default_nettype wire

// ---- verification/erc_tb.sv ----
// Self-checking bench for the enclave re-entry check block.
// Drives every port itself at the falling clock edge; one request is answered one cycle later.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import erc_pkg::*;
    logic clock = 1'b0, rst = 1'b1, start = 1'b0;
    logic [63:0] structPointerOperand, exitPointOperand, enclaveBase, extendedFeatureMask, extendedControlIn;
    logic wideModeFlag, inProtectedMemory, structBusy, enclaveInitialized, enclaveWideMode;
    logic extStateAvailable, osExtStateEnable, trapFlagIn, flagPopTrap, anyMonitorActive;
    logic [127:0] saveAreaHeader;
    erc_map_entry_type mapEntry;
    erc_thread_struct_type threadStruct;
    erc_segment_type segState;
    logic done, savedTrapFlag, trapFlag, optOutActive, suppressOutsideCodeBp, suppressInsideBp, suppressMonitoring;
    erc_fault_type fault;
    logic [63:0] asyncExitPoint, extendedControlReg, savedExtendedControl, perfGlobalStatus, lastExit;
    logic [31:0] saveFrameCount;
    int bad_count = 0, samples_checked = 0, cycles = 0;

    erc_top uut (.clock(clock), .rst(rst), .start(start), .structPointerOperand(structPointerOperand),
        .exitPointOperand(exitPointOperand), .wideModeFlag(wideModeFlag), .inProtectedMemory(inProtectedMemory),
        .structBusy(structBusy), .mapEntry(mapEntry), .threadStruct(threadStruct),
        .enclaveInitialized(enclaveInitialized), .enclaveWideMode(enclaveWideMode), .enclaveBase(enclaveBase),
        .segState(segState), .extStateAvailable(extStateAvailable), .osExtStateEnable(osExtStateEnable),
        .extendedFeatureMask(extendedFeatureMask), .extendedControlIn(extendedControlIn),
        .saveAreaHeader(saveAreaHeader), .trapFlagIn(trapFlagIn), .flagPopTrap(flagPopTrap),
        .anyMonitorActive(anyMonitorActive), .done(done), .fault(fault), .asyncExitPoint(asyncExitPoint),
        .saveFrameCount(saveFrameCount), .extendedControlReg(extendedControlReg),
        .savedExtendedControl(savedExtendedControl), .savedTrapFlag(savedTrapFlag), .trapFlag(trapFlag),
        .optOutActive(optOutActive), .suppressOutsideCodeBp(suppressOutsideCodeBp),
        .suppressInsideBp(suppressInsideBp), .suppressMonitoring(suppressMonitoring),
        .perfGlobalStatus(perfGlobalStatus));

    // ==========================================================
    // Clock, timeout and verdict
    initial begin
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Compare tasks
    task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_fault(input erc_fault_type got, input erc_fault_type exp);
        check_word({62'h0, got}, {62'h0, exp});
    endtask

    // ==========================================================
    // Stimulus helpers
    task automatic set_base(input logic wide);
        structPointerOperand = 64'h0000_0000_0012_3000;
        exitPointOperand = 64'h0000_7FFF_0000_1000;
        wideModeFlag = wide;
        enclaveWideMode = wide;
        inProtectedMemory = 1'b1;
        structBusy = 1'b0;
        mapEntry = '{1'b1, 1'b0, 1'b0, 1'b0, ERC_PT_THREAD, 64'h0000_0000_0012_3000};
        threadStruct = '{64'h2000, 64'h1000, 64'h3000, 64'h0, 32'h3, 32'hFFF, 32'hFFF};
        enclaveInitialized = 1'b1;
        enclaveBase = 64'h0000_0000_0010_0000;
        segState = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 32'hFFFF_FFFF};
        extStateAvailable = 1'b1;
        osExtStateEnable = 1'b1;
        extendedFeatureMask = 64'h7;
        extendedControlIn = 64'h1F;
        saveAreaHeader = {64'h0, 64'h3};
        trapFlagIn = 1'b1;
        flagPopTrap = 1'b0;
        anyMonitorActive = 1'b1;
    endtask

    // One idle edge, request at the next falling edge, answer seen at the one after
    task automatic op();
        @(negedge clock);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        check_word({63'h0, done}, 64'h1);
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_values();
        check_word({63'h0, done}, 64'h0);
        check_word(perfGlobalStatus, 64'h0);
        check_word(asyncExitPoint, 64'h0);
    endtask

    task automatic opt_out_entry();
        set_base(1'b1);
        op();
        check_fault(fault, ERC_FAULT_NONE);
        lastExit = exitPointOperand;
        check_word(asyncExitPoint, lastExit);
        check_word({32'h0, saveFrameCount}, 64'h2);
        check_word(extendedControlReg, 64'h7);
        check_word(savedExtendedControl, 64'h1F);
        check_word({62'h0, savedTrapFlag, trapFlag}, 64'h2);
        check_word({61'h0, suppressOutsideCodeBp, suppressInsideBp, optOutActive}, 64'h7);
        check_word({63'h0, suppressMonitoring}, 64'h1);
        check_word(perfGlobalStatus, 64'h9000_0000_0000_0000);
        flagPopTrap = 1'b1;
        @(negedge clock);
        check_word({63'h0, trapFlag}, 64'h0);
    endtask

    task automatic fault_case(input int i);
        erc_fault_type exp;
        set_base(i < 21);
        exitPointOperand = 64'h0000_0000_0055_5000;
        exp = (i == 1 || (i >= 4 && i <= 9)) ? ERC_FAULT_PF : ERC_FAULT_GP;
        case (i)
            0: begin
                structPointerOperand = 64'h0000_0000_0012_3800;
                mapEntry.enclaveAddress = 64'h0000_0000_0012_3800;
            end
            1: inProtectedMemory = 1'b0;
            2: exitPointOperand = 64'h0000_8000_0000_0000;
            3: structBusy = 1'b1;
            4: mapEntry.valid = 1'b0;
            5: mapEntry.blocked = 1'b1;
            6: mapEntry.pending = 1'b1;
            7: mapEntry.modified = 1'b1;
            8: mapEntry.enclaveAddress = 64'h0000_0000_0012_4000;
            9: mapEntry.pageType = 4'h2;
            10: threadStruct.saveAreaOffset = 64'h2800;
            11: threadStruct.fsBaseOffset = 64'h1010;
            12: threadStruct.gsBaseOffset = 64'h3001;
            13: threadStruct.flags = 64'h2;
            14: enclaveInitialized = 1'b0;
            15: enclaveWideMode = 1'b0;
            16: osExtStateEnable = 1'b0;
            17: extendedFeatureMask = 64'h27;
            18: saveAreaHeader = {64'h0000_0000_0001_0000, 64'h3};
            19: saveAreaHeader = {64'h0, 64'h8};
            20: threadStruct.saveFrameCount = 32'h0;
            21: segState.csBaseZero = 1'b0;
            22: segState.esBaseZero = 1'b0;
            23: segState.ssBigBit = 1'b0;
            24: segState.dsUsable = 1'b0;
            25: segState.dsBit10 = 1'b1;
            default: begin
                segState.dsLimit = 32'h0000_FFFF;
                threadStruct.fsLimit = 32'h0001_0000;
            end
        endcase
        op();
        check_fault(fault, exp);
        check_word(asyncExitPoint, lastExit);
        check_word({32'h0, saveFrameCount}, 64'h2);
        check_word(extendedControlReg, 64'h7);
    endtask

    task automatic fault_range(input int lo, input int hi);
        for (int i = lo; i <= hi; i++) begin
            fault_case(i);
        end
    endtask

    task automatic opt_in_narrow_entry();
        set_base(1'b0);
        threadStruct.flags = 64'h1;
        osExtStateEnable = 1'b0;
        extendedFeatureMask = 64'h3;
        anyMonitorActive = 1'b0;
        op();
        check_fault(fault, ERC_FAULT_NONE);
        check_word(asyncExitPoint, exitPointOperand);
        check_word(extendedControlReg, 64'h7);
        check_word({63'h0, trapFlag}, 64'h1);
        check_word({61'h0, suppressOutsideCodeBp, suppressInsideBp, optOutActive}, 64'h4);
        check_word(perfGlobalStatus, 64'h9000_0000_0000_0000);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        set_base(1'b1);
        repeat (16) @(negedge clock);
        rst = 1'b0;
        reset_values();
        @(negedge clock);
        opt_out_entry();
        fault_range(0, 0);
        fault_range(1, 1);
        fault_range(2, 2);
        fault_range(3, 3);
        fault_range(4, 7);
        fault_range(8, 9);
        fault_range(10, 10);
        fault_range(11, 12);
        fault_range(13, 13);
        fault_range(14, 14);
        fault_range(15, 15);
        fault_range(16, 16);
        fault_range(17, 17);
        fault_range(18, 19);
        fault_range(20, 20);
        fault_range(21, 23);
        fault_range(24, 25);
        fault_range(26, 26);
        opt_in_narrow_entry();
        give_verdict();
    end
endmodule
`default_nettype wire
